// ===== common/ostt_pkg.sv
// Package: register map, fields, reset values and states of the tick timer
package ostt_pkg;

    // Printed register indices; byte address is four times the index
    localparam logic [11:0] OSTT_IDX_IRQ_CTRL   = 12'h055;
    localparam logic [11:0] OSTT_IDX_START      = 12'h380;
    localparam logic [11:0] OSTT_IDX_RELOAD     = 12'h386;
    localparam logic [11:0] OSTT_IDX_MODE       = 12'h396;
    localparam logic [11:0] OSTT_IDX_EV_STATUS  = 12'h3a0;
    localparam logic [11:0] OSTT_IDX_EV_MASK    = 12'h3a1;

    // Field positions
    localparam int OSTT_START_CH0_BIT  = 0;
    localparam int OSTT_IC_LEVEL_LSB   = 0;
    localparam int OSTT_IC_LEVEL_W     = 3;
    localparam int OSTT_IC_REQ_BIT     = 3;
    localparam int OSTT_MODE_OP_LSB    = 0;
    localparam int OSTT_MODE_PULSE_BIT = 2;
    localparam int OSTT_MODE_GATE_LSB  = 3;
    localparam int OSTT_MODE_SRC_LSB   = 6;
    localparam int OSTT_EV_UNDER_BIT   = 0;

    // Field encodings
    localparam logic [1:0] OSTT_OP_TIMER     = 2'h0;
    localparam logic [1:0] OSTT_SRC_DIV1     = 2'h0;
    localparam logic [1:0] OSTT_SRC_DIV8     = 2'h1;
    localparam logic [1:0] OSTT_SRC_DIV32    = 2'h2;
    localparam logic [1:0] OSTT_SRC_SUB_DIV32 = 2'h3;

    // Divider counts
    localparam logic [4:0] OSTT_DIV8_LAST  = 5'h07;
    localparam logic [4:0] OSTT_DIV32_LAST = 5'h1f;

    // Reset values
    localparam logic [7:0]  OSTT_RST_IRQ_CTRL = 8'h00;
    localparam logic [7:0]  OSTT_RST_START    = 8'h00;
    localparam logic [15:0] OSTT_RST_RELOAD   = 16'h0000;
    localparam logic [7:0]  OSTT_RST_MODE     = 8'h00;
    localparam logic [7:0]  OSTT_RST_EV_STAT  = 8'h00;
    localparam logic [7:0]  OSTT_RST_EV_MASK  = 8'h00;

    typedef enum logic [1:0] {
        OSTT_BUS_IDLE,
        OSTT_BUS_WRITE,
        OSTT_BUS_READ_WAIT,
        OSTT_BUS_READ_DONE
    } ostt_bus_e;

endpackage

// ===== core/ostt_counter.sv
// Count-source dividers and 16-bit reloading down counter
module ostt_counter
    import ostt_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        run,
    input  wire logic [1:0]  source_sel,
    input  wire logic        subclock_tick,
    input  wire logic        load_we,
    input  wire logic [15:0] load_value,
    output logic [15:0]      count,
    output logic             underflow
);

    logic [4:0]  hdiv_reg;
    logic [4:0]  sdiv_reg;
    logic [15:0] reload_reg;
    logic        tick;

    // Free-running divider of hclk
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hdiv_reg <= 5'h00;
        else
            hdiv_reg <= hdiv_reg + 5'h01;
    end

    // Divide the sub-clock tick by 32
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            sdiv_reg <= 5'h00;
        else if (subclock_tick)
            sdiv_reg <= sdiv_reg + 5'h01;
    end

    always_comb
    begin
        case (source_sel)
            OSTT_SRC_DIV1:  tick = 1'b1;
            OSTT_SRC_DIV8:  tick = (hdiv_reg[2:0] == OSTT_DIV8_LAST[2:0]);
            OSTT_SRC_DIV32: tick = (hdiv_reg == OSTT_DIV32_LAST);
            default:        tick = subclock_tick
                                   && (sdiv_reg == OSTT_DIV32_LAST);
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            reload_reg <= OSTT_RST_RELOAD;
        else if (load_we)
            reload_reg <= load_value;
    end

    // Stopped: a write loads the counter too; running: next underflow
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            count <= OSTT_RST_RELOAD;
        else if (!run)
        begin
            if (load_we)
                count <= load_value;
        end
        else if (tick)
        begin
            if (count == 16'h0000)
                count <= reload_reg;
            else
                count <= count - 16'h0001;
        end
    end

    assign underflow = run && tick && (count == 16'h0000);

endmodule

// ===== core/ostt_top.sv
// One-second tick timer with AHB-Lite register slave and interrupt
module ostt_top
    import ostt_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        subclock_tick,
    output logic             irq
);

    ostt_bus_e   bus_reg;
    logic [11:0] addr_reg;
    logic [31:0] hrdata_reg;
    logic [2:0]  level_reg;
    logic        req_flag_reg;
    logic [7:0]  ctrl_word;
    logic [7:0]  start_reg;
    logic [7:0]  mode_reg;
    logic [7:0]  ev_stat_reg;
    logic [7:0]  ev_mask_reg;
    logic [15:0] count;
    logic        underflow;
    logic        accept;
    logic        wr_en;
    logic        run;
    logic [31:0] read_word;
    logic        op_timer;
    logic [1:0]  source_sel;
    logic        we_ctrl;
    logic        we_start;
    logic        we_reload;
    logic        we_mode;
    logic        we_stat;
    logic        we_mask;

    function automatic logic hit(input logic [11:0] a,
                                 input logic [11:0] idx);
        hit = (a == idx);
    endfunction

    // Address phase taken when selected, active and bus ready
    assign accept = hsel && htrans[1] && hready;
    assign wr_en  = (bus_reg == OSTT_BUS_WRITE);

    // Per-register write strobes of the data phase
    assign we_ctrl   = wr_en && hit(addr_reg, OSTT_IDX_IRQ_CTRL);
    assign we_start  = wr_en && hit(addr_reg, OSTT_IDX_START);
    assign we_reload = wr_en && hit(addr_reg, OSTT_IDX_RELOAD);
    assign we_mode   = wr_en && hit(addr_reg, OSTT_IDX_MODE);
    assign we_stat   = wr_en && hit(addr_reg, OSTT_IDX_EV_STATUS);
    assign we_mask   = wr_en && hit(addr_reg, OSTT_IDX_EV_MASK);

    // Reads take one wait state so read data comes from a flip-flop
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            bus_reg <= OSTT_BUS_IDLE;
        else
        begin
            case (bus_reg)
                OSTT_BUS_READ_WAIT:
                    bus_reg <= OSTT_BUS_READ_DONE;
                OSTT_BUS_IDLE,
                OSTT_BUS_WRITE,
                OSTT_BUS_READ_DONE:
                begin
                    if (accept && hwrite)
                        bus_reg <= OSTT_BUS_WRITE;
                    else if (accept)
                        bus_reg <= OSTT_BUS_READ_WAIT;
                    else
                        bus_reg <= OSTT_BUS_IDLE;
                end
                default:
                    bus_reg <= OSTT_BUS_IDLE;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            addr_reg <= 12'h000;
        else if (accept && bus_reg != OSTT_BUS_READ_WAIT)
            addr_reg <= haddr[13:2];
    end

    // Low only in the read wait cycle
    assign hreadyout = (bus_reg != OSTT_BUS_READ_WAIT);
    assign hresp     = 1'b0;

    always_comb
    begin
        read_word = 32'h0000_0000;
        if (hit(addr_reg, OSTT_IDX_IRQ_CTRL))
            read_word[7:0] = ctrl_word;
        else if (hit(addr_reg, OSTT_IDX_START))
            read_word[7:0] = start_reg;
        else if (hit(addr_reg, OSTT_IDX_RELOAD))
            read_word[15:0] = count;
        else if (hit(addr_reg, OSTT_IDX_MODE))
            read_word[7:0] = mode_reg;
        else if (hit(addr_reg, OSTT_IDX_EV_STATUS))
            read_word[7:0] = ev_stat_reg;
        else if (hit(addr_reg, OSTT_IDX_EV_MASK))
            read_word[7:0] = ev_mask_reg;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata_reg <= 32'h0000_0000;
        else if (bus_reg == OSTT_BUS_READ_WAIT)
            hrdata_reg <= read_word;
    end

    // Read data stands until the next read's wait cycle
    assign hrdata = hrdata_reg;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            start_reg <= OSTT_RST_START;
        else if (we_start)
            start_reg <= hwdata[7:0];
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            mode_reg <= OSTT_RST_MODE;
        else if (we_mode)
            mode_reg <= hwdata[7:0];
    end

    // Only timer mode counts; gate and pulse fields are stored only
    assign op_timer   = (mode_reg[OSTT_MODE_OP_LSB +: 2] == OSTT_OP_TIMER);
    assign source_sel = mode_reg[OSTT_MODE_SRC_LSB +: 2];
    assign run        = start_reg[OSTT_START_CH0_BIT] && op_timer;

    // Priority level is stored only; nothing here arbitrates it
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            level_reg <=
                OSTT_RST_IRQ_CTRL[OSTT_IC_LEVEL_LSB +: OSTT_IC_LEVEL_W];
        else if (we_ctrl)
            level_reg <= hwdata[OSTT_IC_LEVEL_LSB +: OSTT_IC_LEVEL_W];
    end

    // Request flag: an underflow wins over a software clear
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            req_flag_reg <= OSTT_RST_IRQ_CTRL[OSTT_IC_REQ_BIT];
        else if (underflow)
            req_flag_reg <= 1'b1;
        else if (we_ctrl)
            req_flag_reg <= hwdata[OSTT_IC_REQ_BIT];
    end

    // Upper control bits read as zero
    assign ctrl_word = {4'h0, req_flag_reg, level_reg};

    // Sticky event status, write one to clear, set wins
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            ev_stat_reg <= OSTT_RST_EV_STAT;
        else
        begin
            if (we_stat)
                ev_stat_reg <= ev_stat_reg & ~hwdata[7:0];
            if (underflow)
                ev_stat_reg[OSTT_EV_UNDER_BIT] <= 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            ev_mask_reg <= OSTT_RST_EV_MASK;
        else if (we_mask)
            ev_mask_reg <= hwdata[7:0];
    end

    assign irq = |(ev_stat_reg & ev_mask_reg);

    // Source field selects the count source; 11b is sub-clock/32
    ostt_counter u_counter
    (
        .hclk          (hclk),
        .hresetn       (hresetn),
        .run           (run),
        .source_sel    (source_sel),
        .subclock_tick (subclock_tick),
        .load_we       (we_reload),
        .load_value    (hwdata[15:0]),
        .count         (count),
        .underflow     (underflow)
    );

endmodule

// ===== tb/ostt_top_props.sv
// Checker: bus handshake, response and interrupt properties of the timer
module ostt_top_props
    import ostt_pkg::*;
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic        irq
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire logic take   = hsel && htrans[1] && hready;
    wire logic wr_tak = take && hwrite;
    property p_okay; hresp == 1'b0; endproperty
    property p_rd_wait; take && !hwrite |=> !hreadyout ##1 hreadyout;
    endproperty
    property p_wr_fast; wr_tak |=> hreadyout; endproperty
    property p_rd_hold; $past(hreadyout) && hreadyout |-> $stable(hrdata);
    endproperty
    property p_irq_rst; $rose(hresetn) |-> !irq; endproperty
    // Interrupt level only drops after a register write lands
    property p_irq_fall; $fell(irq) |-> $past(wr_tak, 2); endproperty
    a_okay: assert property (p_okay) else $error("hresp not okay");
    a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
    a_wr_fast: assert property (p_wr_fast) else $error("write stalled");
    a_rd_hold: assert property (p_rd_hold) else $error("hrdata moved");
    a_irq_rst: assert property (p_irq_rst) else $error("irq after reset");
    a_irq_fall: assert property (p_irq_fall) else $error("irq dropped");
    c_read: cover property (take && !hwrite);
    c_write: cover property (wr_tak);
    c_irq: cover property ($rose(irq));
endmodule

bind ostt_top ostt_top_props ostt_top_props_i (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .irq(irq));

// ===== tb/ostt_top_tb.sv
// Testbench: register access, counting, reload and interrupt of the timer
module ostt_top_tb
    import ostt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        subclock_tick = 1'b0;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        irq;
    logic [31:0] x1;
    int          n_mismatch = 0;
    int          num_checks = 0;
    int          cyc = 0;
    int          t0;
    int          t1;
    int          t2;
    logic [11:0] idxs [7] = '{OSTT_IDX_IRQ_CTRL, OSTT_IDX_START,
        OSTT_IDX_RELOAD, OSTT_IDX_MODE, OSTT_IDX_EV_STATUS,
        OSTT_IDX_EV_MASK, 12'h100};

    ostt_top ostt_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .subclock_tick(subclock_tick),
        .irq(irq));

    always #5 hclk = ~hclk;
    always @(posedge hclk) cyc <= cyc + 1;
    // Sub-clock pulse every second bus cycle
    always @(posedge hclk) subclock_tick <= ~subclock_tick;

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wait_rdy();
        int n;
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 20);
        if (hreadyout !== 1'b1)
        begin
            n_mismatch++;
            summarize();
        end
    endtask

    task automatic xfer(input logic [11:0] idx, input logic wr,
                        input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {18'h0, idx, 2'h0};
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask

    task automatic wr(input logic [11:0] idx, input logic [31:0] d);
        logic [31:0] x;
        xfer(idx, 1'b1, d, x);
    endtask

    task automatic rd_chk(input logic [11:0] idx, input logic [31:0] e);
        logic [31:0] x;
        xfer(idx, 1'b0, 32'h0, x);
        check(x, e);
    endtask

    // First look is one edge on, so a just-landed clear is seen
    task automatic wait_irq(output int t);
        int n;
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end
        while (irq !== 1'b1 && n < 70000);
        if (irq !== 1'b1)
        begin
            n_mismatch++;
            summarize();
        end
        t = cyc;
    endtask

    // Reload 3 from stop, then time two underflows
    task automatic period_chk(input logic [31:0] md, input int exp);
        int ta;
        int tb;
        wr(OSTT_IDX_START, 32'h0);
        wr(OSTT_IDX_MODE, md);
        wr(OSTT_IDX_RELOAD, 32'h3);
        wr(OSTT_IDX_EV_STATUS, 32'h1);
        wr(OSTT_IDX_START, 32'h1);
        wait_irq(ta);
        wr(OSTT_IDX_EV_STATUS, 32'h1);
        wait_irq(tb);
        check(32'(tb - ta), 32'(exp));
    endtask

    initial
    begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        foreach (idxs[i]) rd_chk(idxs[i], 32'h0);
        wr(12'h100, 32'hffffffff);
        rd_chk(12'h100, 32'h0);
        wr(OSTT_IDX_IRQ_CTRL, 32'hffffffff);
        rd_chk(OSTT_IDX_IRQ_CTRL, 32'h0000000f);
        wr(OSTT_IDX_IRQ_CTRL, 32'h0);
        rd_chk(OSTT_IDX_IRQ_CTRL, 32'h0);
        $display("test registers done");
        wr(OSTT_IDX_MODE, 32'h0);
        wr(OSTT_IDX_RELOAD, 32'h5);
        repeat (10) @(posedge hclk);
        rd_chk(OSTT_IDX_RELOAD, 32'h5);
        wr(OSTT_IDX_RELOAD, 32'hff);
        wr(OSTT_IDX_EV_MASK, 32'h1);
        wr(OSTT_IDX_START, 32'h1);
        wait_irq(t1);
        rd_chk(OSTT_IDX_IRQ_CTRL, 32'h8);
        wr(OSTT_IDX_EV_STATUS, 32'h1);
        wait_irq(t2);
        check(32'(t2 - t1), 32'h100);
        wr(OSTT_IDX_EV_MASK, 32'h0);
        @(posedge hclk);
        check({31'h0, irq}, 32'h0);
        rd_chk(OSTT_IDX_EV_STATUS, 32'h1);
        wr(OSTT_IDX_START, 32'h0);
        xfer(OSTT_IDX_RELOAD, 1'b0, 32'h0, x1);
        repeat (5) @(posedge hclk);
        rd_chk(OSTT_IDX_RELOAD, x1);
        $display("test periodic done");
        wr(OSTT_IDX_EV_MASK, 32'h1);
        period_chk(32'h40, 32'h20);
        period_chk(32'h80, 32'h80);
        wr(OSTT_IDX_MODE, 32'h81);
        xfer(OSTT_IDX_RELOAD, 1'b0, 32'h0, x1);
        repeat (40) @(posedge hclk);
        rd_chk(OSTT_IDX_RELOAD, x1);
        wr(OSTT_IDX_START, 32'h0);
        $display("test sources done");
        wr(OSTT_IDX_EV_STATUS, 32'h1);
        wr(OSTT_IDX_IRQ_CTRL, 32'h0);
        wr(OSTT_IDX_MODE, 32'hc0);
        rd_chk(OSTT_IDX_MODE, 32'hc0);
        wr(OSTT_IDX_RELOAD, 32'h3ff);
        t0 = cyc;
        wr(OSTT_IDX_START, 32'h1);
        wait_irq(t1);
        check({31'h0, (t1 - t0 > 65460 && t1 - t0 < 65550)}, 32'h1);
        rd_chk(OSTT_IDX_IRQ_CTRL, 32'h8);
        $display("test one second done");
        summarize();
    end
endmodule
